// ---- mgmt_pkg.sv ----
// constants, field layouts and carrier types of the transceiver management block
`default_nettype none
package mgmt_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RESET_MIN_US = 2;
  localparam int unsigned RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
  localparam int unsigned INIT_MS = 2000;
  localparam int unsigned INIT_CYC = INIT_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // lower area byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ID = 8'h00;
  localparam logic [7:0] BYTE_STATUS = 8'h02;
  localparam logic [7:0] BYTE_LOS = 8'h03;
  localparam logic [7:0] BYTE_TXF = 8'h04;
  localparam logic [7:0] BYTE_TEMP = 8'h06;
  localparam logic [7:0] BYTE_VCC = 8'h07;
  localparam logic [7:0] BYTE_TXDIS = 8'h56;
  localparam logic [7:0] BYTE_RXDIS = 8'h57;
  localparam logic [7:0] BYTE_SQDIS = 8'h58;
  localparam logic [7:0] BYTE_POWER = 8'h5d;
  localparam logic [7:0] BYTE_MASK_LOS = 8'h64;
  localparam logic [7:0] BYTE_MASK_TXF = 8'h65;
  localparam logic [7:0] BYTE_MASK_TEMP = 8'h67;
  localparam logic [7:0] BYTE_MASK_VCC = 8'h68;
  localparam logic [7:0] BYTE_PAGE = 8'h7f;

  // ----------------------------------------------------------------
  // pages and field positions
  // ----------------------------------------------------------------
  localparam int UPPER_BIT = 7;
  localparam logic [7:0] PAGE_00 = 8'h00;
  localparam logic [7:0] PAGE_02 = 8'h02;
  localparam logic [7:0] PAGE_03 = 8'h03;
  localparam int STAT_DNR = 0;
  localparam int STAT_IRQ = 1;
  localparam int STAT_FLAT = 2;
  localparam int POW_OVR = 0;
  localparam int POW_SET = 1;
  localparam int SQDIS_BIT = 0;
  localparam int ALARM_LSB = 4;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] tx_dis;
    logic [3:0] rx_dis;
    logic sq_dis;
    logic p_ovr;
    logic p_set;
    logic [7:0] page;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] los;
    logic [3:0] txf;
    logic [3:0] temp;
    logic [3:0] vcc;
  } flags_t;

  localparam ctrl_t CTRL_RESET = '0;
  localparam flags_t FLAGS_RESET = '0;

  typedef enum logic [1:0] {ST_HELD, ST_INIT, ST_READY} init_state_t;

endpackage
`default_nettype wire

// ---- transceiver_mgmt_timing_ctrl.sv ----
// management control, status, flag and page logic of a four-lane pluggable transceiver
`timescale 1ns/1ps
`default_nettype none

// Operation
// - after power-on the module is fully functional within 2000 ms
// - reset pin low longer than 2 us is a reset request; host holds it that long
// - management bus answers within 2000 ms of power-on
// - monitors-pending bit clears and interrupt asserts within 2000 ms of power-on
// - after reset pin rises the module is fully functional within 2000 ms
// - low-power pin high drops the module to power level 1 within 100 us
// - low-power pin low returns the module to full function within 300 ms
// - interrupt pin goes low within 200 ms of any triggering condition
// - after a clearing read the interrupt pin releases within 500 us
// - lane loss of signal sets its loss flag and interrupt within 100 ms
// - lane transmit fault sets its fault flag and interrupt within 200 ms
// - alarms and warnings set their latched flag and interrupt within 200 ms
// - mask set suppresses, mask cleared resumes, interrupt within 100 ms
// - power-down bit set gives level 1 in 100 ms; cleared, full function in 300 ms
// - receive output squelched and restored within 80 us of input loss and return
// - transmit output squelched and restored within 400 ms of input loss and return
// - transmit disable turns optics off in 100 ms, back on in 400 ms
// - receive output disable acts within 100 ms both ways
// - squelch disable switches receive and transmit squelch within 100 ms
// - control response times count from the end of the host write
// - lower 128 bytes always addressable; upper area is selectable pages
// - lower area and pages 00, 02, 03 exist; page 01 does not
// - page select byte in the lower area picks the upper page for later reads
// - bus traffic is answered only while module select is low
// - monitors-pending stays high until monitors are valid, then low; here the init timeout also clears it without valid monitors
// - per-lane loss indications latched in bits 3..0 until read
module transceiver_mgmt_timing_ctrl
  import mgmt_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC,  // init time limit in cycles
  parameter logic [7:0] IDENT_CODE = 8'h00,       // identifier byte, value is arbitrary
  parameter int LANES = 4                          // lane count
) (
  input wire logic ref_clk,                  // 200 MHz clock
  input wire logic nrst,                     // async reset, active low
  input wire logic module_reset_n_pin,       // reset pin from host, active low
  input wire logic low_power_pin,            // low-power pin from host
  input wire logic module_select_n,          // module select, active low
  input wire logic monitors_valid,           // monitor readings are valid
  input wire logic [LANES-1:0] rx_los_in,    // receive loss of signal per lane
  input wire logic [LANES-1:0] tx_fault_in,  // transmit fault per lane
  input wire logic [LANES-1:0] tx_los_in,    // transmit electrical input lost per lane
  input wire logic [7:0] alarm_in,           // temp alarms [7:4], vcc alarms [3:0]
  input wire logic [7:0] addr,               // register byte address
  input wire logic [7:0] wdata,              // write data
  input wire logic wr,                       // write strobe
  input wire logic rd,                       // read strobe
  output logic [7:0] rdata,                  // read data, cycle after rd
  output logic attention_irq_n_o,            // interrupt pin drive level
  output logic attention_irq_n_oe_n,         // interrupt pin enable, low drives
  output logic [LANES-1:0] tx_output_en,     // transmit optical output on
  output logic [LANES-1:0] rx_output_en,     // receive electrical output on
  output logic low_power_state,              // module held at power level 1
  output logic serial_ready                  // bus answers requests
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 3 + 1 + 3 * LANES + 8;
  // idle pin levels: reset pin released, low power off, deselected, no monitors, no conditions
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, 1'b0, 1'b1, {(SYNC_W - 3){1'b0}}};
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic rst_pin_s, lp_pin_s, sel_n_s, mon_valid_s;
  logic [LANES-1:0] rx_los_s, tx_fault_s, tx_los_s;
  logic [7:0] alarm_s;

  // two stages for every pin; only the second stage is read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= SYNC_IDLE; // all-ones would latch every flag right after reset
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {module_reset_n_pin, low_power_pin, module_select_n, monitors_valid,
                 rx_los_in, tx_fault_in, tx_los_in, alarm_in};
      sync_b <= sync_a;
    end
  end

  assign {rst_pin_s, lp_pin_s, sel_n_s, mon_valid_s, rx_los_s, tx_fault_s, tx_los_s, alarm_s} = sync_b;

  // ----------------------------------------------------------------
  // reset pin filter and init sequence
  // ----------------------------------------------------------------
  logic [15:0] low_cnt;
  logic pin_reset;
  logic [31:0] init_cnt;
  init_state_t state;
  logic data_not_ready;
  logic init_event;
  logic init_rd_clear;
  logic next_ready_w;
  assign next_ready_w = mon_valid_s || init_cnt >= 32'(INIT_CYCLES - 1);

  // short glitches below the minimum pulse never reset the module
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= '0;
      pin_reset <= 1'b0;
    end else if (rst_pin_s) begin
      low_cnt <= '0;
      pin_reset <= 1'b0;
    end else if (low_cnt >= 16'(RESET_MIN_CYC)) begin
      pin_reset <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  // init runs after power-on and after each pin reset; timeout forces completion
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_INIT;
      init_cnt <= '0;
    end else if (pin_reset) begin
      state <= ST_HELD;
      init_cnt <= '0;
    end else begin
      case (state)
        ST_HELD: begin
          state <= ST_INIT;
        end
        ST_INIT: begin
          init_cnt <= init_cnt + 32'h0000_0001;
          if (mon_valid_s || init_cnt >= 32'(INIT_CYCLES - 1)) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          state <= ST_READY;
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end

  assign data_not_ready = (state != ST_READY);
  assign serial_ready = !pin_reset && (state != ST_HELD);

  // completion of init posts an interrupt until status byte is read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      init_event <= 1'b0;
    end else if (pin_reset) begin
      init_event <= 1'b0;
    end else if (state == ST_INIT && next_ready_w) begin
      init_event <= 1'b1;
    end else if (init_rd_clear) begin
      init_event <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  logic bus_ok;
  logic wr_ok, rd_ok;
  logic is_upper;
  ctrl_t ctrl;
  flags_t flags;
  flags_t masks;
  logic irq_active;

  // deselected or resetting modules ignore the bus entirely
  assign bus_ok = !sel_n_s && serial_ready;
  assign wr_ok = wr && bus_ok;
  assign rd_ok = rd && bus_ok;
  assign is_upper = addr[UPPER_BIT];
  assign init_rd_clear = rd_ok && addr == BYTE_STATUS;

  // page index into the upper store, invalid for unimplemented pages
  function automatic logic [2:0] page_slot(input logic [7:0] page);
    case (page)
      PAGE_00: page_slot = 3'b100;
      PAGE_02: page_slot = 3'b101;
      PAGE_03: page_slot = 3'b110;
      default: page_slot = 3'b000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // control settings take effect on the write cycle, i.e. at end of write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      masks <= FLAGS_RESET;
    end else if (pin_reset) begin
      ctrl <= CTRL_RESET;
      masks <= FLAGS_RESET;
    end else if (wr_ok && !is_upper) begin
      case (addr)
        BYTE_TXDIS: ctrl.tx_dis <= wdata[LANES-1:0];
        BYTE_RXDIS: ctrl.rx_dis <= wdata[LANES-1:0];
        BYTE_SQDIS: ctrl.sq_dis <= wdata[SQDIS_BIT];
        BYTE_POWER: begin
          ctrl.p_ovr <= wdata[POW_OVR];
          ctrl.p_set <= wdata[POW_SET];
        end
        BYTE_MASK_LOS: masks.los <= wdata[LANES-1:0];
        BYTE_MASK_TXF: masks.txf <= wdata[LANES-1:0];
        BYTE_MASK_TEMP: masks.temp <= wdata[7:ALARM_LSB];
        BYTE_MASK_VCC: masks.vcc <= wdata[7:ALARM_LSB];
        BYTE_PAGE: ctrl.page <= wdata;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // upper page store
  // ----------------------------------------------------------------
  logic [7:0] page_mem [0:3*128-1];
  logic [2:0] slot;
  logic [8:0] mem_idx;
  assign slot = page_slot(ctrl.page);
  assign mem_idx = {slot[1:0], addr[6:0]};

  // page 00 is identification, writes land only in pages 02 and 03
  always_ff @(posedge ref_clk) begin
    if (wr_ok && is_upper && slot[2] && slot[1:0] != 2'b00) begin
      page_mem[mem_idx] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // latched flags, clear on read
  // ----------------------------------------------------------------
  flags_t live;
  flags_t clr;
  assign live = '{los: rx_los_s, txf: tx_fault_s, temp: alarm_s[7:4], vcc: alarm_s[3:0]};

  // a read of a flag byte clears it, but a live condition wins the same cycle
  always_comb begin
    clr = '0;
    if (rd_ok) begin
      case (addr)
        BYTE_LOS: clr.los = '1;
        BYTE_TXF: clr.txf = '1;
        BYTE_TEMP: clr.temp = '1;
        BYTE_VCC: clr.vcc = '1;
        default: clr = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= FLAGS_RESET;
    end else if (pin_reset) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= (flags & ~clr) | live;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  // open-drain: drive low while asserted, else release for the pull-up
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_active <= 1'b0;
    end else begin
      irq_active <= (|(flags & ~masks)) || init_event;
    end
  end

  assign attention_irq_n_o = 1'b0;
  assign attention_irq_n_oe_n = !irq_active;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd_ok && is_upper) begin
      rdata <= slot[2] ? page_mem[mem_idx] : 8'h00;
    end else if (rd_ok) begin
      case (addr)
        BYTE_ID: rdata <= IDENT_CODE;
        BYTE_STATUS: rdata <= 8'((1 << STAT_FLAT) | (int'(!irq_active) << STAT_IRQ)
                                 | (int'(data_not_ready) << STAT_DNR));
        BYTE_LOS: rdata <= {4'h0, flags.los};
        BYTE_TXF: rdata <= {4'h0, flags.txf};
        BYTE_TEMP: rdata <= {flags.temp, 4'h0};
        BYTE_VCC: rdata <= {flags.vcc, 4'h0};
        BYTE_TXDIS: rdata <= {4'h0, ctrl.tx_dis};
        BYTE_RXDIS: rdata <= {4'h0, ctrl.rx_dis};
        BYTE_SQDIS: rdata <= 8'(int'(ctrl.sq_dis) << SQDIS_BIT);
        BYTE_POWER: rdata <= 8'((int'(ctrl.p_set) << POW_SET) | (int'(ctrl.p_ovr) << POW_OVR));
        BYTE_MASK_LOS: rdata <= {4'h0, masks.los};
        BYTE_MASK_TXF: rdata <= {4'h0, masks.txf};
        BYTE_MASK_TEMP: rdata <= {masks.temp, 4'h0};
        BYTE_MASK_VCC: rdata <= {masks.vcc, 4'h0};
        BYTE_PAGE: rdata <= ctrl.page;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // power level and lane outputs
  // ----------------------------------------------------------------
  logic next_low_power;
  assign next_low_power = ctrl.p_ovr ? ctrl.p_set : lp_pin_s;

  // low power shuts the optics; the override bits outrank the pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_power_state <= 1'b1;
    end else begin
      low_power_state <= next_low_power || data_not_ready;
    end
  end

  // squelch follows the live loss state; the disable bit defeats it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_output_en <= '0;
      rx_output_en <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        tx_output_en[i] <= !low_power_state && !ctrl.tx_dis[i]
                           && !(tx_los_s[i] && !ctrl.sq_dis);
        rx_output_en[i] <= !low_power_state && !ctrl.rx_dis[i]
                           && !(rx_los_s[i] && !ctrl.sq_dis);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pin_reset_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(pin_reset) |-> low_cnt == 16'(RESET_MIN_CYC))
    else $error("reset accepted without low pin");
  a_init_timeout: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_INIT && init_cnt >= 32'(INIT_CYCLES - 1) && !pin_reset |=> state == ST_READY)
    else $error("init exceeded its limit");
  a_dnr_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(data_not_ready) && !pin_reset |=> ##1 !attention_irq_n_oe_n)
    else $error("ready without interrupt");
  a_los_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_los_s[0] && !pin_reset |=> flags.los[0] ##1 (masks.los[0] || !attention_irq_n_oe_n))
    else $error("loss not latched or signalled");
  a_txf_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_fault_s[0] && !pin_reset |=> flags.txf[0])
    else $error("fault not latched");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    flags.los[1] && !pin_reset && !(rd_ok && addr == BYTE_LOS) |=> flags.los[1])
    else $error("loss flag dropped without read");
  a_irq_release: assert property (@(posedge ref_clk) disable iff (!nrst)
    (flags & ~masks) == '0 && !init_event |=> attention_irq_n_oe_n)
    else $error("interrupt held with nothing pending");
  a_desel_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd && sel_n_s |=> rdata == 8'h00)
    else $error("answered while deselected");
  a_txdis_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_ok && addr == BYTE_TXDIS && wdata[0] |-> ##2 !tx_output_en[0])
    else $error("tx disable ignored");
  a_rx_squelch: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_los_s[2] && !ctrl.sq_dis |=> !rx_output_en[2])
    else $error("rx not squelched");
  a_lp_enter: assert property (@(posedge ref_clk) disable iff (!nrst)
    lp_pin_s && !ctrl.p_ovr |=> low_power_state)
    else $error("low power pin ignored");

endmodule
`default_nettype wire

// ---- host_model.sv ----
// host side model: register port master and sideband pins of the management block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk,         // block clock
  input wire logic [7:0] rdata,     // read data from block
  output logic module_reset_n_pin,  // reset pin, active low
  output logic low_power_pin,       // low-power pin
  output logic module_select_n,     // select pin, active low
  output logic [7:0] addr,          // byte address
  output logic [7:0] wdata,         // write data
  output logic wr,                  // write strobe
  output logic rd                   // read strobe
);
  // idle levels at time zero, module selected
  initial begin
    module_reset_n_pin = 1'b1;
    low_power_pin = 1'b0;
    module_select_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // register port cycles
  // ----------------------------------------------------------------
  // released data is inverted so a stale value cannot pass unnoticed
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // ----------------------------------------------------------------
  // sideband pins
  // ----------------------------------------------------------------
  task automatic set_pins(input logic rst_n, input logic lp, input logic sel_n);
    @(posedge ref_clk);
    module_reset_n_pin <= rst_n;
    low_power_pin <= lp;
    module_select_n <= sel_n;
  endtask
endmodule
`default_nettype wire

// ---- transceiver_mgmt_timing_ctrl_test.sv ----
// self-checking bench of the transceiver management block
`timescale 1ns/1ps
`default_nettype none
module transceiver_mgmt_timing_ctrl_test;
  import mgmt_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic monitors_valid = 1'b0;
  logic [3:0] rx_los_in = 4'h0;
  logic [3:0] tx_fault_in = 4'h0;
  logic [3:0] tx_los_in = 4'h0;
  logic [7:0] alarm_in = 8'h00;
  logic module_reset_n_pin, low_power_pin, module_select_n, wr, rd, serial_ready;
  logic [7:0] addr, wdata, rdata, d;
  logic attention_irq_n_oe_n, low_power_state;
  logic [3:0] tx_output_en, rx_output_en;
  logic irq_o, irq_pin;
  int n_fail = 0;
  int n_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  // host pull-up resolves the open-drain pin when released
  assign irq_pin = attention_irq_n_oe_n ? 1'b1 : irq_o;

  host_model u_host_model (.ref_clk(ref_clk), .rdata(rdata), .module_reset_n_pin(module_reset_n_pin),
    .low_power_pin(low_power_pin), .module_select_n(module_select_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));

  // short init limit keeps the run brief
  transceiver_mgmt_timing_ctrl #(.INIT_CYCLES(50)) u_transceiver_mgmt_timing_ctrl (.ref_clk(ref_clk),
    .nrst(nrst), .module_reset_n_pin(module_reset_n_pin), .low_power_pin(low_power_pin),
    .module_select_n(module_select_n), .monitors_valid(monitors_valid), .rx_los_in(rx_los_in),
    .tx_fault_in(tx_fault_in), .tx_los_in(tx_los_in), .alarm_in(alarm_in), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .attention_irq_n_o(irq_o), .attention_irq_n_oe_n(attention_irq_n_oe_n),
    .tx_output_en(tx_output_en), .rx_output_en(rx_output_en), .low_power_state(low_power_state),
    .serial_ready(serial_ready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // bounded wait for the interrupt drive to reach a level
  task automatic wait_irq(input logic lvl, input int lim);
    for (int i = 0; i < lim && attention_irq_n_oe_n !== lvl; i++) @(posedge ref_clk);
    #1 check("irq pin", {7'h0, irq_pin}, {7'h0, lvl});
  endtask

  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_init(input logic [7:0] lim);
    wait_irq(1'b0, lim);
    u_host_model.bus_rd(BYTE_STATUS, d);
    check("status", d, 8'h04);
    wait_irq(1'b1, 20);
    check("power level", {7'h0, low_power_state}, 8'h00);
  endtask

  task automatic t_flags;
    logic [7:0] fbyte[4] = '{BYTE_LOS, BYTE_TXF, BYTE_TEMP, BYTE_VCC};
    logic [7:0] fexp[4] = '{8'h03, 8'h05, 8'h80, 8'h10};
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      rx_los_in <= (k == 0) ? 4'h3 : 4'h0;
      tx_fault_in <= (k == 1) ? 4'h5 : 4'h0;
      alarm_in <= (k == 2) ? 8'h80 : (k == 3) ? 8'h01 : 8'h00;
      wait_irq(1'b0, 20);
      @(posedge ref_clk);
      rx_los_in <= 4'h0;
      tx_fault_in <= 4'h0;
      alarm_in <= 8'h00;
      settle();
      u_host_model.bus_rd(fbyte[k], d);
      check("flag byte", d, fexp[k]);
      u_host_model.bus_rd(fbyte[k], d);
      check("flag after read", d, 8'h00);
      wait_irq(1'b1, 20);
    end
  endtask

  // masked loss stays silent, unmasking lets the latched flag through
  task automatic t_mask_squelch;
    u_host_model.bus_wr(BYTE_MASK_LOS, 8'hff);
    @(posedge ref_clk);
    rx_los_in <= 4'hc;
    tx_los_in <= 4'h1;
    settle();
    check("masked irq", {7'h0, attention_irq_n_oe_n}, 8'h01);
    check("rx squelch", {4'h0, rx_output_en}, 8'h03);
    check("tx squelch", {4'h0, tx_output_en}, 8'h0e);
    u_host_model.bus_wr(BYTE_SQDIS, 8'h01);
    settle();
    check("rx no squelch", {4'h0, rx_output_en}, 8'h0f);
    check("tx no squelch", {4'h0, tx_output_en}, 8'h0f);
    u_host_model.bus_wr(BYTE_SQDIS, 8'h00);
    u_host_model.bus_wr(BYTE_MASK_LOS, 8'h00);
    wait_irq(1'b0, 20);
    @(posedge ref_clk);
    rx_los_in <= 4'h0;
    tx_los_in <= 4'h0;
    settle();
    check("rx restored", {4'h0, rx_output_en}, 8'h0f);
    u_host_model.bus_rd(BYTE_LOS, d);
    check("masked flag", d, 8'h0c);
    wait_irq(1'b1, 20);
  endtask

  task automatic t_controls;
    u_host_model.bus_wr(BYTE_TXDIS, 8'h01);
    u_host_model.bus_wr(BYTE_RXDIS, 8'h02);
    settle();
    check("tx disable", {4'h0, tx_output_en}, 8'h0e);
    check("rx disable", {4'h0, rx_output_en}, 8'h0d);
    u_host_model.bus_wr(BYTE_POWER, 8'h03);
    settle();
    check("power down", {7'h0, low_power_state}, 8'h01);
    check("tx off in low power", {4'h0, tx_output_en}, 8'h00);
    u_host_model.bus_wr(BYTE_POWER, 8'h00);
    u_host_model.set_pins(1'b1, 1'b1, 1'b0);
    settle();
    check("pin low power", {7'h0, low_power_state}, 8'h01);
    u_host_model.set_pins(1'b1, 1'b0, 1'b0);
    settle();
    check("pin full power", {7'h0, low_power_state}, 8'h00);
    check("tx kept disabled", {4'h0, tx_output_en}, 8'h0e);
  endtask

  task automatic t_pages;
    u_host_model.bus_wr(BYTE_PAGE, PAGE_02);
    u_host_model.bus_wr(8'h80, 8'h5a);
    u_host_model.bus_wr(BYTE_PAGE, PAGE_03);
    u_host_model.bus_wr(8'h80, 8'hc3);
    u_host_model.bus_rd(8'h80, d);
    check("page 03", d, 8'hc3);
    u_host_model.bus_wr(BYTE_PAGE, PAGE_02);
    u_host_model.bus_rd(8'h80, d);
    check("page 02", d, 8'h5a);
    u_host_model.bus_wr(BYTE_PAGE, 8'h01);
    u_host_model.bus_rd(8'h80, d);
    check("page 01 absent", d, 8'h00);
    u_host_model.bus_rd(BYTE_STATUS, d);
    check("lower area", d, 8'h06);
  endtask

  // deselected traffic is ignored, then a pin reset restarts init
  task automatic t_select_reset;
    u_host_model.set_pins(1'b1, 1'b0, 1'b1);
    settle();
    u_host_model.bus_wr(BYTE_TXDIS, 8'h0f);
    u_host_model.bus_rd(BYTE_STATUS, d);
    check("deselected read", d, 8'h00);
    u_host_model.set_pins(1'b1, 1'b0, 1'b0);
    settle();
    check("write dropped", {4'h0, tx_output_en}, 8'h0e);
    u_host_model.set_pins(1'b0, 1'b0, 1'b0);
    repeat (410) @(posedge ref_clk);
    #1 check("bus held in reset", {7'h0, serial_ready}, 8'h00);
    u_host_model.set_pins(1'b1, 1'b0, 1'b0);
    monitors_valid <= 1'b1;
    t_init(8'd100);
    check("controls reset", {4'h0, tx_output_en}, 8'h0f);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    #1 check("irq idle", {7'h0, attention_irq_n_oe_n}, 8'h01);
    check("held low power", {7'h0, low_power_state}, 8'h01);
    t_init(8'd80);
    t_flags();
    t_mask_squelch();
    t_controls();
    t_pages();
    t_select_reset();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
